// file: bench/xbs_crossbar_tb.sv
// Self-checking bench for the crossbar switch and its target model.
// Assumes every access is answered within 200 cycles.
`timescale 1ns/1ns
`default_nettype none
module xbs_crossbar_tb;
    import xbs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] mreq = '0, mwe = '0, ack, err, treq, tack, twe;
    logic [4:0][31:0] ma = '0, mwd = '0, mrd, ta, twd, trd, la, lw;
    logic [4:0][3:0] mbe = '0, tbe;
    logic brst;
    logic [31:0] ctl_wd = '0;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    int done_at [5];
    int dec_t [16] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 1, -1, -1, -1, -1, -1};
    logic [3:0] dec_be [16] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
        4'hf, 4'hf, 4'h8, 4'hf, 4'hf, 4'hf, 4'h1, 4'h8};
    logic [31:0] dec_a [16] = '{32'h0005_fffc, 32'h1003_fffc, 32'h8000_0000, 32'h9fff_fffc,
        32'h4000_0000, 32'h4a00_007c, 32'h5400_0000, 32'h56ff_fffc, 32'h6000_0000, 32'h6200_81fc,
        32'hf000_0008, 32'h3000_0000, 32'h4a00_0080, 32'h6100_8080, 32'h4000_0000, 32'hf000_0000};
    initial forever #2 clk = ~clk;
    xbs_crossbar u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_m_req(mreq), .i_m_addr(ma), .i_m_we(mwe),
        .i_m_be(mbe), .i_m_wdata(mwd), .o_m_ack(ack), .o_m_err(err), .o_m_rdata(mrd), .o_t_req(treq),
        .o_t_addr(ta), .o_t_we(twe), .o_t_be(tbe), .o_t_wdata(twd), .i_t_ack(tack), .i_t_rdata(trd),
        .o_mem_bridge_reset(brst));
    xbs_tgt_model u_tgt (.i_clk(clk), .i_nrst(nrst), .i_req(treq), .i_addr(ta), .i_wd(twd),
        .o_ack(tack), .o_rd(trd), .o_la(la), .o_lw(lw));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One access; t below zero means served inside the switch
    task automatic acc(input int m, input logic [31:0] a, input logic [3:0] be, input logic we,
        input logic xe, input int t);
        int n;
        n = 0;
        @(posedge clk);
        ma[m] <= a;
        mbe[m] <= be;
        mwe[m] <= we;
        mwd[m] <= (a == 32'h4000_0024) ? ctl_wd : ~a;
        mreq[m] <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ack[m] !== 1'b1 && err[m] !== 1'b1 && n < 200);
        mreq[m] <= 1'b0;
        done_at[m] = cyc;
        chk("answered", {31'h0, ack[m] | err[m]}, 32'h1);
        chk("err flag", {31'h0, err[m]}, {31'h0, xe});
        if (!xe && t >= 0) begin
            chk("target addr", la[t], a);
            chk("target we", {31'h0, twe[t]}, {31'h0, we});
            chk("target be", {28'h0, tbe[t]}, {28'h0, be});
            if (we) chk("target wdata", lw[t], ~a);
            else chk("read data", mrd[m], a ^ 32'h5a5a_5a5a);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        chk("bridge reset", {31'h0, brst}, 32'h1);
        acc(0, 32'h4000_0024, 4'hf, 1'b0, 1'b0, -1);
        chk("ctl read", mrd[0], 32'h1);
        acc(4, 32'h1000_0000, 4'hf, 1'b0, 1'b1, 0);
        acc(0, 32'h4000_0024, 4'hf, 1'b1, 1'b0, -1);
        chk("bridge released", {31'h0, brst}, 32'h0);
        acc(4, 32'h1000_0000, 4'hf, 1'b0, 1'b0, 0);
        $display("test bridge control done");
        foreach (dec_a[i]) begin
            acc(2 + i % 2, dec_a[i], dec_be[i], i[0], dec_t[i] < 0, dec_t[i]);
        end
        $display("test decode done");
        fork
            acc(2, 32'h4200_0000, 4'hf, 1'b0, 1'b0, 2);
            acc(3, 32'h4700_0000, 4'hf, 1'b0, 1'b0, 2);
        join
        chk("hi before lo", {31'h0, done_at[2] < done_at[3]}, 32'h1);
        fork
            acc(1, 32'h8000_0010, 4'hf, 1'b0, 1'b0, 1);
            acc(0, 32'h8000_0020, 4'hf, 1'b0, 1'b0, 1);
        join
        chk("fill ranks last", {31'h0, done_at[0] < done_at[1]}, 32'h1);
        $display("test arbitration done");
        fork
            acc(3, 32'h5500_0000, 4'hf, 1'b1, 1'b0, 3);
            acc(4, 32'h9000_0000, 4'hf, 1'b1, 1'b0, 1);
        join
        chk("parallel", {31'h0, (done_at[3] - done_at[4]) inside {[-2:2]}}, 32'h1);
        fork
            acc(4, 32'h1000_0010, 4'hf, 1'b1, 1'b0, 0);
            acc(0, 32'h4700_0010, 4'hf, 1'b1, 1'b0, 2);
        join
        chk("mem and cfg parallel", {31'h0, done_at[4] == done_at[0]}, 32'h1);
        $display("test concurrency done");
        ctl_wd = 32'h1;
        fork
            acc(4, 32'h1000_0020, 4'hf, 1'b0, 1'b1, 0);
            acc(0, 32'h4000_0024, 4'hf, 1'b1, 1'b0, -1);
        join
        chk("reset mid access", {31'h0, brst}, 32'h1);
        ctl_wd = 32'h0;
        acc(0, 32'h4000_0024, 4'hf, 1'b1, 1'b0, -1);
        chk("bridge released again", {31'h0, brst}, 32'h0);
        $display("test bridge reset in flight done");
        conclude();
    end
endmodule
`default_nettype wire

// file: bench/xbs_tgt_model.sv
// Target-side stand-in for all five targets of the switch.
// Assumes the switch holds each o_t_req until the ack edge.
`timescale 1ns/1ns
`default_nettype none
module xbs_tgt_model #(
    parameter int DLY = 2
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [4:0] i_req,
    input wire logic [4:0][31:0] i_addr,
    input wire logic [4:0][31:0] i_wd,
    output logic [4:0] o_ack,
    output logic [4:0][31:0] o_rd,
    output logic [4:0][31:0] o_la,
    output logic [4:0][31:0] o_lw
);
    int cnt [5];
    always_ff @(posedge i_clk or negedge i_nrst) begin
        for (int t = 0; t < 5; t++) begin
            if (!i_nrst) begin
                o_ack[t] <= 1'b0;
                cnt[t] <= 0;
            end else if (i_req[t] && !o_ack[t] && cnt[t] == DLY) begin
                o_ack[t] <= 1'b1;
                o_rd[t] <= i_addr[t] ^ 32'h5a5a_5a5a;
                o_la[t] <= i_addr[t];
                o_lw[t] <= i_wd[t];
                cnt[t] <= 0;
            end else begin
                o_ack[t] <= 1'b0;
                o_rd[t] <= ~o_rd[t]; // Stale data must not look valid
                cnt[t] <= (i_req[t] && !o_ack[t]) ? cnt[t] + 1 : 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: src/xbs_arbiter.sv
// Fixed-priority, non-preemptive arbiter for one target of the crossbar.
// Requesters hold their request until the owner's access is reported done.
`timescale 1ns/1ns
`default_nettype none
`include "xbs_consts.svh"
module xbs_arbiter #(
    parameter int N = xbs_pkg::XBS_NM,
    parameter logic [3*N-1:0] PRIO = `XBS_PRIO_STD
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [N-1:0] i_req,
    input wire logic i_done,
    output logic [N-1:0] o_grant,
    output logic [2:0] o_gidx,
    output logic o_busy,
    output logic o_start
);
    import xbs_pkg::*;
    xbs_arb_e state_q, state_d;
    logic [N-1:0] grant_q, grant_d, pick;
    logic [2:0] gidx_q, gidx_d, pidx;
    logic start_q, start_d;

    for (genvar k = 0; k < N; k++) begin : g_chk
        if (N > 8 || PRIO[3*k+:3] >= N) begin : g_bad
            $error("arbiter priority entry out of range");
        end
    end

    // Scan lowest rank first so the highest rank overwrites
    always_comb begin
        pick = '0;
        pidx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[PRIO[3*k+:3]]) begin
                pick = '0;
                pick[PRIO[3*k+:3]] = 1'b1;
                pidx = PRIO[3*k+:3];
            end
        end
    end

    always_comb begin
        state_d = state_q;
        grant_d = grant_q;
        gidx_d = gidx_q;
        start_d = 1'b0;
        unique case (state_q)
            XBS_ARB_IDLE: if (|i_req) begin
                state_d = XBS_ARB_BUSY;
                grant_d = pick;
                gidx_d = pidx;
                start_d = 1'b1;
            end
            XBS_ARB_BUSY: if (i_done) begin
                state_d = XBS_ARB_IDLE;
                grant_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= XBS_ARB_IDLE;
            grant_q <= '0;
            gidx_q <= '0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            grant_q <= grant_d;
            gidx_q <= gidx_d;
            start_q <= start_d;
        end
    end

    assign o_grant = grant_q;
    assign o_gidx = gidx_q;
    assign o_busy = (state_q == XBS_ARB_BUSY);
    assign o_start = start_q;

    a_grant_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $onehot0(grant_q) && (o_busy == (grant_q != '0))) else $error("grant not one-hot");
    a_owner_held: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (o_busy && !i_done) |=> o_busy && $stable(grant_q)) else $error("owner lost before done");
    a_prio_pick: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!o_busy && |i_req) |=> o_start && grant_q == $past(pick)) else $error("wrong master granted");
endmodule
`default_nettype wire

// file: src/xbs_bridge.sv
// Small request FIFO between the arbiter and the issue stage of a target.
// Flush empties it at once; stored words are then lost.
`timescale 1ns/1ns
`default_nettype none
`include "xbs_consts.svh"
module xbs_bridge #(
    parameter int W = xbs_pkg::XBS_RQW,
    parameter int DEPTH = `XBS_BR_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
        $error("bridge depth must be a power of two, at least 2");
    end

    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;
    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + AW'(1) : wr_q;
            rd_q <= pop ? rd_q + AW'(1) : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; the count guards it
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    a_count_bound: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (cnt_q <= (AW+1)'(DEPTH)) && (o_in_ready || cnt_q == (AW+1)'(DEPTH))) else $error("fifo count overflow");
    a_flush_empty: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_flush |=> !o_out_valid && o_in_ready) else $error("flush left data");
    a_push_count: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (push && !pop && !i_flush) |=> cnt_q == $past(cnt_q) + (AW+1)'(1)) else $error("push not counted");
endmodule
`default_nettype wire

// file: src/xbs_consts.svh
// Address map, register and default constants for the crossbar switch.
// Included by the arbiter, bridge and crossbar files of the block; holds definitions only.
`ifndef XBS_CONSTS_SVH
`define XBS_CONSTS_SVH
`define XBS_ROM_END 32'h0005_ffff
`define XBS_RAM_BASE 32'h1000_0000
`define XBS_RAM_END 32'h1003_ffff
`define XBS_PG_CFG_LO 8'h40
`define XBS_PG_CFG_HI 8'h4a
`define XBS_PG_PLL 8'h41
`define XBS_PG_RTI 8'h42
`define XBS_PG_HPI 8'h43
`define XBS_PG_ACTL_LO 8'h44
`define XBS_PG_ACTL_HI 8'h46
`define XBS_LIM_DEV 24'h00_0083
`define XBS_LIM_PLL 24'h00_015f
`define XBS_LIM_RTI 24'h00_00a3
`define XBS_LIM_HPI 24'h00_0043
`define XBS_LIM_ACTL 24'h00_02bf
`define XBS_LIM_SER 24'h00_007f
`define XBS_PG_AUD_LO 8'h54
`define XBS_PG_AUD_HI 8'h56
`define XBS_DCTL_BASE 32'h6000_0000
`define XBS_DCTL_END 32'h6000_008f
`define XBS_PG_TAB_LO 8'h61
`define XBS_PG_TAB_HI 8'h62
`define XBS_TAB_EVT_BASE 24'h00_8000
`define XBS_TAB_EVT_END 24'h00_807f
`define XBS_TAB_XFR_BASE 24'h00_80a0
`define XBS_TAB_XFR_END 24'h00_81ff
`define XBS_NIB_SDRAM 4'h8
`define XBS_NIB_ASYNC 4'h9
`define XBS_NIB_EMC 4'hf
`define XBS_EMC_BASE 32'hf000_0000
`define XBS_EMC_END 32'hf000_00bf
`define XBS_SDRAM_CONFIG_REG_DEF 32'hf000_0008
`define XBS_BRCTL_ADDR 32'h4000_0024
`define XBS_BRCTL_BIT 0
`define XBS_BRCTL_RST 1'b1
`define XBS_BE_WORD 4'hf
`define XBS_BE_TOP 4'h8
`define XBS_PRIO_STD 15'h18d0
`define XBS_PRIO_EXT 15'h111a
`define XBS_BR_DEPTH 4
`endif

// file: src/xbs_crossbar.sv
// Five-master, five-target crossbar switch with per-target bridges and
// the bridge control register. Masters and targets are on-chip logic
// on one clock; masters hold a request stable until answered.
`timescale 1ns/1ns
`default_nettype none
`include "xbs_consts.svh"
module xbs_crossbar #(
    parameter logic [xbs_pkg::XBS_NT:0][3*xbs_pkg::XBS_NM-1:0] PRIO = {
        `XBS_PRIO_STD, `XBS_PRIO_STD, `XBS_PRIO_STD,
        `XBS_PRIO_STD, `XBS_PRIO_EXT, `XBS_PRIO_STD},
    parameter logic [31:0] SDRAM_CONFIG_REG_ADDR = `XBS_SDRAM_CONFIG_REG_DEF,
    parameter int BR_DEPTH = `XBS_BR_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [xbs_pkg::XBS_NM-1:0] i_m_req,
    input wire logic [xbs_pkg::XBS_NM-1:0][31:0] i_m_addr,
    input wire logic [xbs_pkg::XBS_NM-1:0] i_m_we,
    input wire logic [xbs_pkg::XBS_NM-1:0][3:0] i_m_be,
    input wire logic [xbs_pkg::XBS_NM-1:0][31:0] i_m_wdata,
    output logic [xbs_pkg::XBS_NM-1:0] o_m_ack,
    output logic [xbs_pkg::XBS_NM-1:0] o_m_err,
    output logic [xbs_pkg::XBS_NM-1:0][31:0] o_m_rdata,
    output logic [xbs_pkg::XBS_NT-1:0] o_t_req,
    output logic [xbs_pkg::XBS_NT-1:0][31:0] o_t_addr,
    output logic [xbs_pkg::XBS_NT-1:0] o_t_we,
    output logic [xbs_pkg::XBS_NT-1:0][3:0] o_t_be,
    output logic [xbs_pkg::XBS_NT-1:0][31:0] o_t_wdata,
    input wire logic [xbs_pkg::XBS_NT-1:0] i_t_ack,
    input wire logic [xbs_pkg::XBS_NT-1:0][31:0] i_t_rdata,
    output logic o_mem_bridge_reset
);
    import xbs_pkg::*;
    localparam int NA = XBS_NT + 1;

    function automatic int xbs_rank(input logic [3*XBS_NM-1:0] p, input logic [2:0] id);
        int r;
        r = XBS_NM;
        for (int k = XBS_NM - 1; k >= 0; k--) begin
            if (p[3*k+:3] == id) begin
                r = k;
            end
        end
        return r;
    endfunction

    function automatic xbs_tgt_e xbs_decode(input logic [31:0] a, input logic [3:0] be,
                                            input logic [31:0] sdram_config_reg, input logic flush);
        logic word;
        logic [7:0] pg;
        logic [23:0] lo;
        logic [23:0] lim;
        xbs_tgt_e t;
        word = (be == `XBS_BE_WORD);
        pg = a[31:24];
        lo = a[23:0];
        t = XBS_T_ERR;
        if (pg == `XBS_PG_CFG_LO) begin
            lim = `XBS_LIM_DEV;
        end else if (pg == `XBS_PG_PLL) begin
            lim = `XBS_LIM_PLL;
        end else if (pg == `XBS_PG_RTI) begin
            lim = `XBS_LIM_RTI;
        end else if (pg == `XBS_PG_HPI) begin
            lim = `XBS_LIM_HPI;
        end else if (pg >= `XBS_PG_ACTL_LO && pg <= `XBS_PG_ACTL_HI) begin
            lim = `XBS_LIM_ACTL;
        end else begin
            lim = `XBS_LIM_SER;
        end
        if (a <= `XBS_ROM_END) begin
            t = XBS_T_MEM;
        end else if (a >= `XBS_RAM_BASE && a <= `XBS_RAM_END) begin
            t = XBS_T_MEM;
        end else if (pg >= `XBS_PG_CFG_LO && pg <= `XBS_PG_CFG_HI) begin
            if (word && lo <= lim) begin
                t = (a == `XBS_BRCTL_ADDR) ? XBS_T_LOCAL : XBS_T_CFG;
            end
        end else if (pg >= `XBS_PG_AUD_LO && pg <= `XBS_PG_AUD_HI) begin
            t = word ? XBS_T_AUD : XBS_T_ERR;
        end else if (a >= `XBS_DCTL_BASE && a <= `XBS_DCTL_END) begin
            t = word ? XBS_T_DREG : XBS_T_ERR;
        end else if (pg == `XBS_PG_TAB_LO || pg == `XBS_PG_TAB_HI) begin
            if ((lo >= `XBS_TAB_EVT_BASE && lo <= `XBS_TAB_EVT_END) ||
                (lo >= `XBS_TAB_XFR_BASE && lo <= `XBS_TAB_XFR_END)) begin
                t = XBS_T_DREG;
            end
        end else if (a[31:28] == `XBS_NIB_SDRAM || a[31:28] == `XBS_NIB_ASYNC) begin
            t = XBS_T_EXT;
        end else if (a >= `XBS_EMC_BASE && a <= `XBS_EMC_END) begin
            if (word || (a == sdram_config_reg && be == `XBS_BE_TOP)) begin
                t = XBS_T_EXT;
            end
        end
        // Refuse memory accesses while its bridge is held in reset
        if (t == XBS_T_MEM && flush) begin
            t = XBS_T_ERR;
        end
        return t;
    endfunction

    for (genvar t = 0; t < NA; t++) begin : g_prio_chk
        if (xbs_rank(PRIO[t], XBS_M_DMA_HI) > xbs_rank(PRIO[t], XBS_M_DMA_LO)) begin : g_bad
            $error("low dma port ranked above high dma port");
        end
    end
    if (xbs_rank(PRIO[XBS_T_EXT], XBS_M_PFILL) != XBS_NM - 1) begin : g_fill_chk
        $error("program fill must rank last on external memory");
    end

    logic [XBS_NM-1:0] ack_q, ack_d, err_q, err_d;
    logic [XBS_NM-1:0][31:0] rdata_q, rdata_d;
    logic brctl_q, brctl_d;
    logic [XBS_NT-1:0] treq_q, twe_q;
    logic [XBS_NT-1:0][31:0] taddr_q, twdata_q;
    logic [XBS_NT-1:0][3:0] tbe_q;
    logic [XBS_NT-1:0][2:0] tid_q;
    xbs_tgt_e m_tgt [XBS_NM];
    logic [XBS_NM-1:0] m_live;
    logic [NA-1:0][XBS_NM-1:0] a_req, a_grant;
    logic [NA-1:0] a_done, a_busy, a_start;
    logic [NA-1:0][2:0] a_gidx;
    logic [XBS_NT-1:0] b_in_ready, b_out_valid, b_out_ready, t_flush;
    logic [XBS_NT-1:0][XBS_RQW-1:0] b_in_data, b_out_data;

    // A master is not taken again in the cycle its answer shows
    for (genvar m = 0; m < XBS_NM; m++) begin : g_mst
        assign m_tgt[m] = xbs_decode(i_m_addr[m], i_m_be[m], SDRAM_CONFIG_REG_ADDR, brctl_q);
        assign m_live[m] = i_m_req[m] & ~ack_q[m] & ~err_q[m];

        a_unmapped_err: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
            (m_live[m] && m_tgt[m] == XBS_T_ERR) |=> o_m_err[m] && !o_m_ack[m])
            else $error("bad address not refused");

        a_answer_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
            (ack_q[m] || err_q[m]) |=> !ack_q[m] && !err_q[m])
            else $error("answer longer than one cycle");
    end

    for (genvar t = 0; t < NA; t++) begin : g_arb
        for (genvar m = 0; m < XBS_NM; m++) begin : g_req
            assign a_req[t][m] = m_live[m] & (m_tgt[m] == xbs_tgt_e'(t));
        end
        xbs_arbiter #(
            .N(XBS_NM),
            .PRIO(PRIO[t])
        ) u_arb (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .i_req(a_req[t]),
            .i_done(a_done[t]),
            .o_grant(a_grant[t]),
            .o_gidx(a_gidx[t]),
            .o_busy(a_busy[t]),
            .o_start(a_start[t])
        );
    end

    // Local register access completes in its first owned cycle
    assign a_done[NA-1] = a_busy[NA-1];

    for (genvar t = 0; t < XBS_NT; t++) begin : g_tgt
        // Only the onchip memory bridge has a software reset
        assign t_flush[t] = (t == XBS_T_MEM) ? brctl_q : 1'b0;
        assign a_done[t] = (i_t_ack[t] & treq_q[t]) | (t_flush[t] & a_busy[t]);
        assign b_in_data[t] = {a_gidx[t], i_m_we[a_gidx[t]], i_m_be[a_gidx[t]],
                               i_m_addr[a_gidx[t]], i_m_wdata[a_gidx[t]]};
        assign b_out_ready[t] = ~treq_q[t];

        xbs_bridge #(
            .W(XBS_RQW),
            .DEPTH(BR_DEPTH)
        ) u_bridge (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .i_flush(t_flush[t]),
            .i_in_valid(a_start[t]),
            .o_in_ready(b_in_ready[t]),
            .i_in_data(b_in_data[t]),
            .o_out_valid(b_out_valid[t]),
            .i_out_ready(b_out_ready[t]),
            .o_out_data(b_out_data[t])
        );

        always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
                treq_q[t] <= 1'b0;
                {tid_q[t], twe_q[t], tbe_q[t], taddr_q[t], twdata_q[t]} <= '0;
            end else if (t_flush[t]) begin
                treq_q[t] <= 1'b0;
            end else if (b_out_valid[t] && !treq_q[t]) begin
                treq_q[t] <= 1'b1;
                {tid_q[t], twe_q[t], tbe_q[t], taddr_q[t], twdata_q[t]} <= b_out_data[t];
            end else if (i_t_ack[t]) begin
                treq_q[t] <= 1'b0;
            end
        end

        a_bridge_room: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
            a_start[t] |-> b_in_ready[t]) else $error("bridge full on grant");

        a_ack_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
            (treq_q[t] && i_t_ack[t] && !t_flush[t]) |=> ack_q[$past(tid_q[t])])
            else $error("target answer not returned to its master");
        // Fields stay frozen until the target's ack edge
        a_treq_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
            (treq_q[t] && !i_t_ack[t] && !t_flush[t]) |=> treq_q[t] && $stable(taddr_q[t]) &&
            $stable(twdata_q[t]) && $stable(tbe_q[t]) && $stable(twe_q[t]))
            else $error("target request changed before ack");
    end

    wire [2:0] lg = a_gidx[NA-1];
    wire [2:0] mg = a_gidx[XBS_T_MEM];

    always_comb begin
        ack_d = '0;
        err_d = '0;
        rdata_d = rdata_q;
        brctl_d = brctl_q;
        for (int t = 0; t < XBS_NT; t++) begin
            if (treq_q[t] && i_t_ack[t] && !t_flush[t]) begin
                ack_d[tid_q[t]] = 1'b1;
                rdata_d[tid_q[t]] = i_t_rdata[t];
            end
        end
        for (int m = 0; m < XBS_NM; m++) begin
            if (m_live[m] && m_tgt[m] == XBS_T_ERR) begin
                err_d[m] = 1'b1;
            end
        end
        // An access caught by the bridge reset is answered with an error
        if (brctl_q && a_busy[XBS_T_MEM]) begin
            err_d[mg] = 1'b1;
        end
        if (a_busy[NA-1]) begin
            ack_d[lg] = 1'b1;
            rdata_d[lg] = '0;
            rdata_d[lg][`XBS_BRCTL_BIT] = brctl_q;
            if (i_m_we[lg]) begin
                brctl_d = i_m_wdata[lg][`XBS_BRCTL_BIT];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= '0;
            err_q <= '0;
            rdata_q <= '0;
            brctl_q <= `XBS_BRCTL_RST;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
            brctl_q <= brctl_d;
        end
    end

    assign o_m_ack = ack_q;
    assign o_m_err = err_q;
    assign o_m_rdata = rdata_q;
    assign o_t_req = treq_q;
    assign o_t_addr = taddr_q;
    assign o_t_we = twe_q;
    assign o_t_be = tbe_q;
    assign o_t_wdata = twdata_q;
    assign o_mem_bridge_reset = brctl_q;

    a_mem_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        treq_q[XBS_T_MEM] |-> (taddr_q[XBS_T_MEM] <= `XBS_ROM_END) ||
        (taddr_q[XBS_T_MEM] >= `XBS_RAM_BASE && taddr_q[XBS_T_MEM] <= `XBS_RAM_END))
        else $error("memory port got foreign address");
    a_ext_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        treq_q[XBS_T_EXT] |-> taddr_q[XBS_T_EXT][31:28] inside {`XBS_NIB_SDRAM, `XBS_NIB_ASYNC, `XBS_NIB_EMC})
        else $error("external port got foreign address");
    a_sdram_config_reg_byte: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (treq_q[XBS_T_EXT] && taddr_q[XBS_T_EXT][31:28] == `XBS_NIB_EMC && tbe_q[XBS_T_EXT] != `XBS_BE_WORD)
        |-> taddr_q[XBS_T_EXT] == SDRAM_CONFIG_REG_ADDR && tbe_q[XBS_T_EXT] == `XBS_BE_TOP)
        else $error("byte access to word-only control register");
    a_aud_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        treq_q[XBS_T_AUD] |-> tbe_q[XBS_T_AUD] == `XBS_BE_WORD &&
        taddr_q[XBS_T_AUD][31:24] >= `XBS_PG_AUD_LO && taddr_q[XBS_T_AUD][31:24] <= `XBS_PG_AUD_HI)
        else $error("audio port got bad access");
    a_dreg_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        treq_q[XBS_T_DREG] |-> taddr_q[XBS_T_DREG][31:24] >= `XBS_DCTL_BASE >> 24 &&
        taddr_q[XBS_T_DREG][31:24] <= `XBS_PG_TAB_HI)
        else $error("dma register port got foreign address");
    a_cfg_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        treq_q[XBS_T_CFG] |-> tbe_q[XBS_T_CFG] == `XBS_BE_WORD && taddr_q[XBS_T_CFG] != `XBS_BRCTL_ADDR &&
        taddr_q[XBS_T_CFG][31:24] >= `XBS_PG_CFG_LO && taddr_q[XBS_T_CFG][31:24] <= `XBS_PG_CFG_HI)
        else $error("config bus got bad access");
    a_flush_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        brctl_q |=> !treq_q[XBS_T_MEM] && !a_busy[XBS_T_MEM])
        else $error("memory access issued during bridge reset");
    a_concurrent: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (a_req[XBS_T_CFG] != '0 && a_req[XBS_T_MEM] != '0 && !a_busy[XBS_T_CFG] && !a_busy[XBS_T_MEM])
        |=> a_busy[XBS_T_CFG] && a_busy[XBS_T_MEM])
        else $error("independent targets not granted together");
    a_dma_order: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (a_req[XBS_T_CFG][XBS_M_DMA_HI] && a_req[XBS_T_CFG][XBS_M_DMA_LO] && !a_busy[XBS_T_CFG])
        |=> !a_grant[XBS_T_CFG][XBS_M_DMA_LO])
        else $error("low dma port won over high dma port");

    // Local register answers in the cycle after its owned cycle
    a_local_ack: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        a_busy[NA-1] |=> ack_q[$past(lg)] && !a_busy[NA-1])
        else $error("bridge control access not answered");
    a_ctl_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (a_busy[NA-1] && i_m_we[lg]) |=> brctl_q == $past(i_m_wdata[lg][`XBS_BRCTL_BIT]))
        else $error("bridge control write lost");
    a_err_mem: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (brctl_q && a_busy[XBS_T_MEM]) |=> err_q[$past(mg)])
        else $error("memory owner not refused on bridge reset");
    // Fill must lose any tie on external memory
    a_fill_last: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (a_req[XBS_T_EXT][XBS_M_PFILL] && $countones(a_req[XBS_T_EXT]) > 1 && !a_busy[XBS_T_EXT])
        |=> !a_grant[XBS_T_EXT][XBS_M_PFILL])
        else $error("program fill won external memory over another master");
endmodule
`default_nettype wire

// file: src/xbs_pkg.sv
// Types shared by the crossbar switch files.
// Needs nothing from its surroundings.
package xbs_pkg;
    localparam int XBS_NM = 5;
    localparam int XBS_NT = 5;
    localparam int XBS_IW = 3;
    localparam int XBS_RQW = XBS_IW + 1 + 4 + 32 + 32;
    typedef enum logic [2:0] {
        XBS_M_CPU = 3'b000,
        XBS_M_PFILL = 3'b001,
        XBS_M_DMA_HI = 3'b010,
        XBS_M_DMA_LO = 3'b011,
        XBS_M_HOST = 3'b100
    } xbs_mst_e;
    typedef enum logic [2:0] {
        XBS_T_MEM = 3'b000,
        XBS_T_EXT = 3'b001,
        XBS_T_CFG = 3'b010,
        XBS_T_AUD = 3'b011,
        XBS_T_DREG = 3'b100,
        XBS_T_LOCAL = 3'b101,
        XBS_T_ERR = 3'b110
    } xbs_tgt_e;
    typedef enum logic {
        XBS_ARB_IDLE = 1'b0,
        XBS_ARB_BUSY = 1'b1
    } xbs_arb_e;
    typedef logic [3*XBS_NM-1:0] xbs_prio_t;
endpackage
